//--- motdet_pkg.sv
// constants for the motion detect and sample buffer control block
// assumes a single clock domain shared with the sample source and register port
package motdet_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] MOTDET_ADDR_INACT_LOW  = 8'h25;
  localparam logic [7:0] MOTDET_ADDR_INACT_HIGH = 8'h26;
  localparam logic [7:0] MOTDET_ADDR_CONTROL    = 8'h27;
  localparam logic [7:0] MOTDET_ADDR_BUF_CFG    = 8'h28;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MOTDET_RST_INACT_LOW  = 8'h00;
  localparam logic [7:0] MOTDET_RST_INACT_HIGH = 8'h00;
  localparam logic [7:0] MOTDET_RST_CONTROL    = 8'h00;
  localparam logic [7:0] MOTDET_RST_BUF_CFG    = 8'h00;
  localparam logic [7:0] MOTDET_RDATA_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int MOTDET_MOTION_EN_BIT  = 0;
  localparam int MOTDET_MOTION_REF_BIT = 1;
  localparam int MOTDET_STILL_EN_BIT   = 2;
  localparam int MOTDET_STILL_REF_BIT  = 3;
  localparam int MOTDET_SEQ_LO_BIT     = 4;
  localparam int MOTDET_SEQ_HI_BIT     = 5;

  // ---------------------------------------------------------------
  // buffer config field positions
  // ---------------------------------------------------------------
  localparam int MOTDET_BUF_MODE_LO_BIT = 0;
  localparam int MOTDET_BUF_MODE_HI_BIT = 1;
  localparam int MOTDET_BUF_TEMP_BIT    = 2;
  localparam int MOTDET_BUF_MSB_BIT     = 3;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int          MOTDET_SAMPLE_W     = 12;
  localparam int          MOTDET_THRESH_W     = 11;
  localparam int          MOTDET_COUNT_W      = 16;
  localparam logic [15:0] MOTDET_MOTION_COUNT = 16'h0001;

  typedef enum logic [1:0] {
    MOTDET_BUF_OFF,
    MOTDET_BUF_OLDEST,
    MOTDET_BUF_STREAM,
    MOTDET_BUF_TRIGGERED
  } motdet_buf_mode_e;

endpackage

//--- motdet_sample_if.sv
// sample carrier between the control block and its detectors
// assumes producer and consumers share clk_i
`timescale 1ns/1ps
`default_nettype none
interface motdet_sample_if;
  import motdet_pkg::*;
  logic                              valid;
  logic signed [MOTDET_SAMPLE_W-1:0] axis [3];

  modport src (output valid, output axis);
  modport dst (input valid, input axis);
endinterface
`default_nettype wire

//--- motdet_detector.sv
// one threshold detector with consecutive sample counting
// assumes samples arrive as single-cycle valid pulses on clk_i
`timescale 1ns/1ps
`default_nettype none
module motdet_detector
  import motdet_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // samples
  motdet_sample_if.dst                    smp,
  // configuration
  input  wire logic                       armed_i,
  input  wire logic                       referenced_i,
  input  wire logic                       over_mode_i,
  input  wire logic [MOTDET_THRESH_W-1:0] threshold_i,
  input  wire logic [MOTDET_COUNT_W-1:0]  need_count_i,
  // result
  output logic                            event_o
);

  logic signed [MOTDET_SAMPLE_W-1:0] ref_axis [3];
  logic                              ref_ok;
  logic [2:0]                        over_axis;
  logic [2:0]                        under_axis;
  logic                              hit;
  logic [MOTDET_COUNT_W-1:0]         count;
  logic [MOTDET_COUNT_W-1:0]         need;
  logic [MOTDET_COUNT_W-1:0]         next_count;

  // ---------------------------------------------------------------
  // per-axis magnitude compare
  // ---------------------------------------------------------------
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [MOTDET_SAMPLE_W:0] diff;
    logic        [MOTDET_SAMPLE_W:0] mag;
    logic        [MOTDET_SAMPLE_W:0] thr_wide;
    // referenced mode subtracts the captured baseline
    assign diff = referenced_i ? (MOTDET_SAMPLE_W+1)'(smp.axis[a] - ref_axis[a])
                               : (MOTDET_SAMPLE_W+1)'(smp.axis[a]);  // [R7] [R9]
    assign mag        = diff[MOTDET_SAMPLE_W] ? (MOTDET_SAMPLE_W+1)'(-diff) : diff;  // [R16]
    assign thr_wide   = (MOTDET_SAMPLE_W+1)'(threshold_i);
    assign over_axis[a]  = mag > thr_wide;
    assign under_axis[a] = mag < thr_wide;  // [R16]

    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        ref_axis[a] <= '0;
      end else if (armed_i && smp.valid && !ref_ok) begin
        ref_axis[a] <= smp.axis[a];
      end
    end
  end

  // activity needs any axis over, inactivity needs every axis under
  assign hit = over_mode_i ? |over_axis : &under_axis;  // [R14]
  // a programmed zero behaves as one sample
  assign need       = (need_count_i == '0) ? MOTDET_MOTION_COUNT : need_count_i;  // [R2]
  assign next_count = count + MOTDET_MOTION_COUNT;

  // ---------------------------------------------------------------
  // consecutive sample counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count   <= '0;
      event_o <= 1'b0;
    end else begin
      event_o <= 1'b0;
      if (!armed_i) begin
        count <= '0;
      end else if (smp.valid) begin
        // the first sample only seeds the baseline in referenced mode
        if (referenced_i && !ref_ok) begin
          count <= '0;
        end else if (!hit) begin
          count <= '0;  // [R14]
        end else if (next_count >= need) begin
          count   <= '0;
          event_o <= 1'b1;  // [R1] [R14]
        end else begin
          count <= next_count;
        end
      end
    end
  end

  // baseline is retaken after every event so referenced mode tracks posture
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ref_ok <= 1'b0;
    end else if (!armed_i || event_o) begin
      ref_ok <= 1'b0;
    end else if (smp.valid) begin
      ref_ok <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- motdet_top.sv
// motion detect control registers, sequencing and buffer configuration
// assumes register port, sample source and status reader share clk_i
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: inactivity duration is a 16-bit sample count
// R2: duration zero acts as one sample
// R3: mode X0 arms both, host acknowledges
// R4: mode 01 alternates, host acknowledges
// R5: mode 11 alternates, acknowledged internally
// R6: sequencing needs both enable bits set
// R7: control bit 3 selects referenced inactivity
// R8: control bit 2 enables inactivity detection
// R9: control bit 1 selects referenced activity
// R10: control bit 0 enables activity detection
// R11: buffer bit 3 is sample count msb
// R12: buffer bit 2 stores temperature samples
// R13: buffer mode field selects buffer behaviour
// R14: inactivity needs consecutive all-axis under samples
// R15: low byte plus high byte form count
// R16: magnitude of signed sample versus threshold
// R17: sequencing starts armed for activity, alternates
// R18: unused bits store and read back
module motdet_top
  import motdet_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // register port
  input  wire logic [7:0]                  reg_addr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  input  wire logic                        reg_write_i,
  input  wire logic                        reg_read_i,
  output logic      [7:0]                  reg_rdata_o,
  // acceleration samples
  input  wire logic                        sample_valid_i,
  input  wire logic [MOTDET_SAMPLE_W-1:0]  sample_x_i,
  input  wire logic [MOTDET_SAMPLE_W-1:0]  sample_y_i,
  input  wire logic [MOTDET_SAMPLE_W-1:0]  sample_z_i,
  // thresholds held elsewhere
  input  wire logic [MOTDET_THRESH_W-1:0]  motion_threshold_i,
  input  wire logic [MOTDET_THRESH_W-1:0]  still_threshold_i,
  // status acknowledge and buffer sample count low byte
  input  wire logic                        status_read_i,
  input  wire logic [7:0]                  buffer_samples_low_i,
  // detection state
  output logic                             motion_armed_o,
  output logic                             still_armed_o,
  output logic                             motion_flag_o,
  output logic                             still_flag_o,
  output logic                             autosleep_allowed_o,
  // buffer configuration
  output motdet_buf_mode_e                 buffer_mode_o,
  output logic                             buffer_store_temp_o,
  output logic      [8:0]                  buffer_sample_count_o
);

  typedef enum logic {MOTDET_SEQ_MOTION, MOTDET_SEQ_STILL} motdet_seq_e;

  logic [7:0]                inactivity_time_low;
  logic [7:0]                inactivity_time_high;
  logic [7:0]                motion_detect_control;
  logic [7:0]                sample_buffer_config;
  logic [MOTDET_COUNT_W-1:0] inactivity_sample_count;
  logic [1:0]                sequencing_mode_field;
  logic                      motion_detect_enable;
  logic                      still_detect_enable;
  logic                      sequenced;
  logic                      loop_mode;
  logic                      motion_armed;
  logic                      still_armed;
  logic                      motion_event;
  logic                      still_event;
  motdet_seq_e               seq_state;

  motdet_sample_if smp_bus ();

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      inactivity_time_low   <= MOTDET_RST_INACT_LOW;
      inactivity_time_high  <= MOTDET_RST_INACT_HIGH;
      motion_detect_control <= MOTDET_RST_CONTROL;
      sample_buffer_config  <= MOTDET_RST_BUF_CFG;
    end else if (reg_write_i) begin
      // whole bytes stored so unused bits read back as written
      unique case (reg_addr_i)
        MOTDET_ADDR_INACT_LOW:  inactivity_time_low   <= reg_wdata_i;  // [R15]
        MOTDET_ADDR_INACT_HIGH: inactivity_time_high  <= reg_wdata_i;  // [R15]
        MOTDET_ADDR_CONTROL:    motion_detect_control <= reg_wdata_i;  // [R18]
        MOTDET_ADDR_BUF_CFG:    sample_buffer_config  <= reg_wdata_i;  // [R18]
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads, answered one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= MOTDET_RDATA_UNMAPPED;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        MOTDET_ADDR_INACT_LOW:  reg_rdata_o <= inactivity_time_low;
        MOTDET_ADDR_INACT_HIGH: reg_rdata_o <= inactivity_time_high;
        MOTDET_ADDR_CONTROL:    reg_rdata_o <= motion_detect_control;  // [R18]
        MOTDET_ADDR_BUF_CFG:    reg_rdata_o <= sample_buffer_config;   // [R18]
        default:                reg_rdata_o <= MOTDET_RDATA_UNMAPPED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  assign inactivity_sample_count = {inactivity_time_high, inactivity_time_low};  // [R1] [R15]
  assign sequencing_mode_field   = motion_detect_control[MOTDET_SEQ_HI_BIT:MOTDET_SEQ_LO_BIT];
  assign motion_detect_enable    = motion_detect_control[MOTDET_MOTION_EN_BIT];  // [R10]
  assign still_detect_enable     = motion_detect_control[MOTDET_STILL_EN_BIT];   // [R8]
  // linked or loop only when both detectors are enabled
  assign sequenced = sequencing_mode_field[0] && motion_detect_enable && still_detect_enable;  // [R6]
  assign loop_mode = sequenced && sequencing_mode_field[1];  // [R5]

  // default mode arms each enabled detector at once
  assign motion_armed = sequenced ? (seq_state == MOTDET_SEQ_MOTION) : motion_detect_enable;  // [R3] [R4] [R10]
  assign still_armed  = sequenced ? (seq_state == MOTDET_SEQ_STILL)  : still_detect_enable;   // [R3] [R4] [R8]

  // ---------------------------------------------------------------
  // sequencing state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      seq_state <= MOTDET_SEQ_MOTION;
    end else if (!sequenced) begin
      seq_state <= MOTDET_SEQ_MOTION;  // [R17]
    end else begin
      unique case (seq_state)
        MOTDET_SEQ_MOTION: if (motion_event) seq_state <= MOTDET_SEQ_STILL;   // [R17]
        MOTDET_SEQ_STILL:  if (still_event)  seq_state <= MOTDET_SEQ_MOTION;  // [R17]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // detectors
  // ---------------------------------------------------------------
  assign smp_bus.valid   = sample_valid_i;
  assign smp_bus.axis[0] = sample_x_i;
  assign smp_bus.axis[1] = sample_y_i;
  assign smp_bus.axis[2] = sample_z_i;

  motdet_detector u_motion (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .smp          (smp_bus),
    .armed_i      (motion_armed),
    .referenced_i (motion_detect_control[MOTDET_MOTION_REF_BIT]),  // [R9]
    .over_mode_i  (1'b1),
    .threshold_i  (motion_threshold_i),
    .need_count_i (MOTDET_MOTION_COUNT),
    .event_o      (motion_event)
  );

  motdet_detector u_still (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .smp          (smp_bus),
    .armed_i      (still_armed),
    .referenced_i (motion_detect_control[MOTDET_STILL_REF_BIT]),  // [R7]
    .over_mode_i  (1'b0),
    .threshold_i  (still_threshold_i),
    .need_count_i (inactivity_sample_count),  // [R1]
    .event_o      (still_event)
  );

  // ---------------------------------------------------------------
  // event flags; a new event beats a same-cycle acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      motion_flag_o <= 1'b0;
      still_flag_o  <= 1'b0;
    end else begin
      // loop mode acks itself, so a flag stands one cycle only
      if (motion_event) begin
        motion_flag_o <= 1'b1;
      end else if (loop_mode || status_read_i) begin
        motion_flag_o <= 1'b0;  // [R3] [R4] [R5]
      end
      if (still_event) begin
        still_flag_o <= 1'b1;
      end else if (loop_mode || status_read_i) begin
        still_flag_o <= 1'b0;  // [R3] [R4] [R5]
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      motion_armed_o      <= 1'b0;
      still_armed_o       <= 1'b0;
      autosleep_allowed_o <= 1'b0;
    end else begin
      motion_armed_o      <= motion_armed;
      still_armed_o       <= still_armed;
      autosleep_allowed_o <= sequenced;  // [R3]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      buffer_mode_o         <= MOTDET_BUF_OFF;
      buffer_store_temp_o   <= 1'b0;
      buffer_sample_count_o <= '0;
    end else begin
      buffer_mode_o         <= motdet_buf_mode_e'(
                               sample_buffer_config[MOTDET_BUF_MODE_HI_BIT:MOTDET_BUF_MODE_LO_BIT]);  // [R13]
      buffer_store_temp_o   <= sample_buffer_config[MOTDET_BUF_TEMP_BIT];  // [R12]
      buffer_sample_count_o <= {sample_buffer_config[MOTDET_BUF_MSB_BIT], buffer_samples_low_i};  // [R11]
    end
  end

endmodule
`default_nettype wire

//--- motdet_properties.sv
// concurrent checks on the ports of motdet_top
// assumes the register port is the only path that changes the four registers
`timescale 1ns/1ps
`default_nettype none
module motdet_props_chk
  import motdet_pkg::*;
(
  // clock and reset
  input wire logic             clk_i,
  input wire logic             reset_n_i,
  // register port and status
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_write_i,
  input wire logic             reg_read_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic             status_read_i,
  input wire logic [7:0]       buffer_samples_low_i,
  // outputs
  input wire logic             motion_armed_o,
  input wire logic             still_armed_o,
  input wire logic             motion_flag_o,
  input wire logic             still_flag_o,
  input wire logic             autosleep_allowed_o,
  input wire logic [1:0]       buffer_mode_o,
  input wire logic             buffer_store_temp_o,
  input wire logic [8:0]       buffer_sample_count_o
);
  // ------
  // shadow registers
  // ------
  logic [7:0] sh [4];
  logic [7:0] ctl_d;
  logic [7:0] buf_d;
  logic [7:0] exp_rd;
  logic       seq_eff;
  logic       loop_eff;

  // index by the low address bits: 0x28 lands on 0
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sh <= '{default: 8'h00};
    end else if (reg_write_i && reg_addr_i inside {[8'h25:8'h28]}) begin
      sh[reg_addr_i[1:0]] <= reg_wdata_i;
    end
  end

  // derived outputs trail the register by one cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctl_d <= 8'h00;
      buf_d <= 8'h00;
    end else begin
      ctl_d <= sh[3];
      buf_d <= sh[0];
    end
  end

  always_comb begin
    exp_rd = MOTDET_RDATA_UNMAPPED;
    if (reg_addr_i inside {[8'h25:8'h28]}) begin
      exp_rd = sh[reg_addr_i[1:0]];
    end
  end

  assign seq_eff  = ctl_d[4] & ctl_d[0] & ctl_d[2];
  assign loop_eff = seq_eff & ctl_d[5];

  // ------
  // properties
  // ------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_read_value: assert property (reg_read_i |=> reg_rdata_o == $past(exp_rd))
    else $error("read data differs from stored register");
  a_autosleep_seq: assert property (autosleep_allowed_o == seq_eff)
    else $error("autosleep differs from sequencing in effect");
  a_buffer_mode: assert property (buffer_mode_o == buf_d[1:0])
    else $error("buffer mode differs from config field");
  a_buffer_temp: assert property (buffer_store_temp_o == buf_d[2])
    else $error("store temperature differs from config bit");
  a_count_bits: assert property ($past(reset_n_i) |-> buffer_sample_count_o == {buf_d[3], $past(buffer_samples_low_i)})
    else $error("buffer sample count not formed from msb and low byte");
  a_one_armed: assert property (seq_eff && $past(seq_eff) |-> !(motion_armed_o && still_armed_o))
    else $error("both detectors armed while sequenced");
  a_both_armed: assert property (!seq_eff && ctl_d[0] && ctl_d[2] && $past(ctl_d) == ctl_d
                                 |-> motion_armed_o && still_armed_o)
    else $error("default mode does not arm both detectors");
  // the flag clears on the live register, so the trailing copy must agree with it
  a_flag_sticky: assert property (!loop_eff && ctl_d == sh[3] && still_flag_o && !status_read_i
                                  |=> still_flag_o)
    else $error("still flag dropped without status read");
  a_loop_pulse: assert property (loop_eff && $past(loop_eff)
                                 |-> !(motion_flag_o && $past(motion_flag_o)) && !(still_flag_o && $past(still_flag_o)))
    else $error("loop mode flag held longer than one cycle");
endmodule

bind motdet_top motdet_props_chk u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .status_read_i(status_read_i),
  .buffer_samples_low_i(buffer_samples_low_i), .motion_armed_o(motion_armed_o), .still_armed_o(still_armed_o),
  .motion_flag_o(motion_flag_o), .still_flag_o(still_flag_o), .autosleep_allowed_o(autosleep_allowed_o),
  .buffer_mode_o(buffer_mode_o), .buffer_store_temp_o(buffer_store_temp_o),
  .buffer_sample_count_o(buffer_sample_count_o)
);
`default_nettype wire

//--- motdet_tb.sv
// self-checking bench for motdet_top: registers, buffer setup, detection
// assumes motdet_properties.sv is compiled alongside and binds itself
`timescale 1ns/1ps
`default_nettype none
module motdet_tb;
  import motdet_pkg::*;
  // ------
  // signals and design
  // ------
  logic             clk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             wr = 1'b0, rd = 1'b0, vld = 1'b0, sts = 1'b0;
  logic [7:0]       addr = 8'h00, wdata = 8'h00, low = 8'h00, rdata;
  logic [11:0]      sx = 12'h000, sy = 12'h000, sz = 12'h000;
  logic [10:0]      mthr = 11'h000, sthr = 11'h064;
  logic             marm, sarm, mflg, sflg, slp, btemp;
  logic [8:0]       bcnt;
  motdet_buf_mode_e bmode;
  int               err_count = 0, cmp_count = 0;
  logic [7:0]       rd_q[$], ev_q[$];
  logic             prd = 1'b0, psf = 1'b0, pmf = 1'b0;

  always #50 clk_i = ~clk_i;

  motdet_top u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
    .reg_read_i(rd), .reg_rdata_o(rdata), .sample_valid_i(vld), .sample_x_i(sx), .sample_y_i(sy),
    .sample_z_i(sz), .motion_threshold_i(mthr), .still_threshold_i(sthr), .status_read_i(sts),
    .buffer_samples_low_i(low), .motion_armed_o(marm), .still_armed_o(sarm), .motion_flag_o(mflg),
    .still_flag_o(sflg), .autosleep_allowed_o(slp), .buffer_mode_o(bmode), .buffer_store_temp_o(btemp),
    .buffer_sample_count_o(bcnt)
  );

  // ------
  // tasks
  // ------
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask

  // back to back writes, the last one to an unmapped place
  task automatic wburst(logic [7:0] d[4]);
    @(negedge clk_i);
    wr = 1'b1;
    for (int k = 0; k < 5; k++) begin
      addr = 8'h25 + 8'(k);
      wdata = (k < 4) ? d[k] : 8'hff;
      @(negedge clk_i);
    end
    wr = 1'b0;
  endtask

  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    rd_q.push_back(e);
    @(negedge clk_i);
    rd = 1'b0;
  endtask

  // ev names the event this sample must raise, zero for none
  task automatic smp(logic [11:0] x, logic [11:0] y, logic [11:0] z, logic [7:0] ev);
    @(negedge clk_i);
    sx = x;
    sy = y;
    sz = z;
    vld = 1'b1;
    if (ev != 8'h00) ev_q.push_back(ev);
    @(negedge clk_i);
    vld = 1'b0;
  endtask

  task automatic ack();
    @(negedge clk_i);
    sts = 1'b1;
    @(negedge clk_i);
    sts = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  // magnitude strictly under 100
  function automatic logic [11:0] under();
    return 12'($urandom_range(198)) - 12'h063;
  endfunction

  always @(posedge clk_i) prd <= rd;
  always @(negedge clk_i) begin
    if (prd) cmp("read data", rd_q.pop_front(), rdata);
    if (sflg && !psf) cmp("still event", 8'h53, ev_q.size() ? ev_q.pop_front() : 8'h00);
    if (mflg && !pmf) cmp("motion event", 8'h4d, ev_q.size() ? ev_q.pop_front() : 8'h00);
    psf = sflg;
    pmf = mflg;
  end

  // ------
  // tests
  // ------
  initial begin
    logic [7:0]  v[4];
    logic [15:0] cnt[4];
    logic [7:0]  md[2];
    int          n;
    void'($urandom(32'h09a20881));
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int a = 8'h24; a <= 8'h29; a++) rreg(8'(a), 8'h00);
    cmp("buffer mode", MOTDET_BUF_OFF, bmode);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      foreach (v[k]) v[k] = 8'($urandom);
      v[3][1:0] = 2'(i);
      low = 8'($urandom);
      wburst(v);
      for (int k = 0; k < 5; k++) rreg(8'h25 + 8'(k), (k < 4) ? v[k] : 8'h00);
      cmp("buffer mode", 16'(i), bmode);
      cmp("store temp", v[3][2], btemp);
      cmp("sample count", {v[3][3], low}, bcnt);
    end
    $display("register test done");
    wreg(8'h27, 8'h04);
    cnt = '{16'h0000, 16'h0001, 16'h0003, 16'h0102};
    foreach (cnt[i]) begin
      wreg(8'h25, cnt[i][7:0]);
      wreg(8'h26, cnt[i][15:8]);
      n = (cnt[i] == 16'h0000) ? 1 : int'(cnt[i]);
      smp(12'hf9c, 12'h000, 12'h000, 8'h00);
      for (int j = 1; j < n; j++) smp(under(), under(), under(), 8'h00);
      smp(under(), 12'hf9c, under(), 8'h00);
      for (int j = 1; j <= n; j++) smp(under(), under(), under(), (j == n) ? 8'h53 : 8'h00);
      repeat (4) @(negedge clk_i);
      cmp("still flag", 16'h1, sflg);
      ack();
      cmp("still flag cleared", 16'h0, sflg);
    end
    $display("inactivity count test done");
    mthr = 11'h064;
    // high byte still holds the last long count
    wreg(8'h26, 8'h00);
    md = '{8'h15, 8'h35};
    foreach (md[i]) begin
      wreg(8'h25, 8'h02);
      wreg(8'h27, md[i]);
      repeat (3) @(negedge clk_i);
      cmp("autosleep", 16'h1, slp);
      cmp("armed", 16'h2, {marm, sarm});
      smp(12'h064, 12'hf9c, 12'h000, 8'h00);
      smp(md[i][5] ? 12'h065 : 12'hf9b, 12'h000, 12'h000, 8'h4d);
      repeat (4) @(negedge clk_i);
      cmp("armed", 16'h1, {marm, sarm});
      cmp("motion flag", 16'(!md[i][5]), mflg);
      smp(12'h000, 12'h000, 12'h000, 8'h00);
      smp(12'h000, 12'h000, 12'h000, 8'h53);
      repeat (4) @(negedge clk_i);
      cmp("armed", 16'h2, {marm, sarm});
      cmp("still flag", 16'(!md[i][5]), sflg);
      ack();
    end
    wreg(8'h27, 8'h34);
    repeat (3) @(negedge clk_i);
    cmp("fallback armed", 16'h1, {marm, sarm});
    wreg(8'h27, 8'h05);
    repeat (3) @(negedge clk_i);
    cmp("default armed", 16'h3, {marm, sarm});
    cmp("default autosleep", 16'h0, slp);
    $display("sequencing test done");
    wreg(8'h27, 8'h00);
    wreg(8'h27, 8'h03);
    smp(12'h3e8, 12'h000, 12'h000, 8'h00);
    smp(12'h44c, 12'h000, 12'h000, 8'h00);
    smp(12'h44d, 12'h000, 12'h000, 8'h4d);
    repeat (4) @(negedge clk_i);
    ack();
    wreg(8'h25, 8'h01);
    wreg(8'h27, 8'h0c);
    smp(12'h5dc, 12'h5dc, 12'ha24, 8'h00);
    smp(12'h5e0, 12'h5d8, 12'ha24, 8'h53);
    repeat (4) @(negedge clk_i);
    ack();
    cmp("events left", 16'h0, 16'(ev_q.size()));
    $display("referenced test done");
    print_verdict();
  end

  // whole run is about 1300 cycles
  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
